// [pkg/tsof_regs.vh]
`ifndef TSOF_REGS_VH
`define TSOF_REGS_VH

// ==========================================
// Register byte offsets
`define TSOF_OFS_CTRL 5'h00
`define TSOF_OFS_NCO 5'h04
`define TSOF_OFS_DECIM 5'h08
`define TSOF_OFS_AGCTHR 5'h0c
`define TSOF_OFS_SHIFT 5'h10
`define TSOF_OFS_STATUS 5'h14

// ==========================================
// Control fields
`define TSOF_CTRL_ENABLE 0
`define TSOF_CTRL_MUX 1
`define TSOF_CTRL_AGC 2
// Status fields
`define TSOF_ST_GAINA_LO 0
`define TSOF_ST_GAINB_LO 2
`define TSOF_ST_OVERRUN 4

// ==========================================
// Reset values
`define TSOF_RST_CTRL 3'h7
`define TSOF_RST_NCO 32'h1d89d89d
`define TSOF_RST_DECIM 16'h00c0
`define TSOF_RST_AGCTHR 12'h600
`define TSOF_RST_SHIFT 5'h00

// ==========================================
// Serial link format and timing; AGC gain limit
`define TSOF_WORD_BITS 24
`define TSOF_BITCNT_LAST 5'h17
`define TSOF_GAIN_MAX 2'h3
`define TSOF_CORE_CLK_HZ 20000000
`define TSOF_SCLK_DIV 2

`endif

// [design/tsof_formatter.v]
`timescale 1ns/10ps
`include "tsof_regs.vh"

// ==========================================
// Small word FIFO
module tsof_fifo #(
	parameter WIDTH = 26,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Fill side
	input wire [WIDTH-1:0] inData,
	input wire inValid,
	output wire inReady,
	// Drain side
	output wire [WIDTH-1:0] outData,
	output wire outValid,
	input wire outReady
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr_reg;
	reg [AW-1:0] rdPtr_reg;
	reg [AW:0] count_reg;
	wire doPush;
	wire doPop;

	// Honest full and empty from the occupancy count
	assign inReady = (count_reg != DEPTH[AW:0]);
	assign outValid = (count_reg != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_reg];
	assign doPush = inValid && inReady;
	assign doPop = outValid && outReady;

	// Storage, no reset needed on the data
	always @(posedge clk)
	begin
		if (doPush)
			mem[wrPtr_reg] <= inData;
	end

	// Pointers wrap at DEPTH
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wrPtr_reg <= {AW{1'b0}};
			rdPtr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (doPush)
				wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
			if (doPop)
				rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
			if (doPush && !doPop)
				count_reg <= count_reg + 1'b1;
			else if (doPop && !doPush)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule // tsof_fifo

// Operation
// - default mux on, 24-bit serial words
// - one frame sync per I/Q pair
// - channels A and B share pin A
// - bit clock is half core clock
// - mix to baseband, filter, decimate
// - default decimation 192
// - gain control steers external amplifiers
// - gain steps compensated digitally
// - mixer, decimation, filter, gain programmable
// - filter rejects alias image near fs
module tsof_formatter #(
	parameter ADC_W = 12,
	parameter ACC_W = 24,
	parameter FIFO_DEPTH = 4
) (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Avalon-MM slave
	input wire [4:0] avsAddress,
	input wire avsRead,
	input wire avsWrite,
	input wire [31:0] avsWriteData,
	output reg [31:0] avsReadData,
	output reg avsWaitrequest,
	// Sampled IF from the converters
	input wire [ADC_W-1:0] adcDataA,
	input wire [ADC_W-1:0] adcDataB,
	// Variable gain amplifier steps
	output wire [1:0] vgaGainA,
	output wire [1:0] vgaGainB,
	// Serial link
	output reg serialBitClock,
	output reg serialFrameSync,
	output reg channelASerialOut,
	output reg outputReady
);
	// ==========================================
	// Registers
	reg [2:0] ctrl_reg;
	reg [31:0] nco_reg;
	reg [15:0] decim_reg;
	reg [ADC_W-1:0] agcThr_reg;
	reg [4:0] shift_reg;
	reg overrun_reg;
	wire enable = ctrl_reg[`TSOF_CTRL_ENABLE];
	wire channelMuxSelect = ctrl_reg[`TSOF_CTRL_MUX];
	wire agcEnable = ctrl_reg[`TSOF_CTRL_AGC];
	wire busReq = avsRead || avsWrite;
	wire busDone = busReq && !avsWaitrequest;

	// One wait state: answer at the second edge of a request
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			avsWaitrequest <= 1'b1;
		else if (busReq && avsWaitrequest)
			avsWaitrequest <= 1'b0;
		else
			avsWaitrequest <= 1'b1;
	end

	// Writes take effect only at the accepting edge
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_reg <= `TSOF_RST_CTRL;
			nco_reg <= `TSOF_RST_NCO;
			decim_reg <= `TSOF_RST_DECIM;
			agcThr_reg <= `TSOF_RST_AGCTHR;
			shift_reg <= `TSOF_RST_SHIFT;
		end
		else if (busDone && avsWrite)
		begin
			case (avsAddress)
				`TSOF_OFS_CTRL: ctrl_reg <= avsWriteData[2:0];
				`TSOF_OFS_NCO: nco_reg <= avsWriteData;
				`TSOF_OFS_DECIM: decim_reg <= avsWriteData[15:0];
				`TSOF_OFS_AGCTHR: agcThr_reg <= avsWriteData[ADC_W-1:0];
				`TSOF_OFS_SHIFT: shift_reg <= avsWriteData[4:0];
				default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// Read data registered while wait is asserted; unmapped reads zero
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			avsReadData <= 32'h00000000;
		else if (avsRead && avsWaitrequest)
		begin
			case (avsAddress)
				`TSOF_OFS_CTRL: avsReadData <= {29'h0000000, ctrl_reg};
				`TSOF_OFS_NCO: avsReadData <= nco_reg;
				`TSOF_OFS_DECIM: avsReadData <= {16'h0000, decim_reg};
				`TSOF_OFS_AGCTHR: avsReadData <= {{(32-ADC_W){1'b0}}, agcThr_reg};
				`TSOF_OFS_SHIFT: avsReadData <= {27'h0000000, shift_reg};
				`TSOF_OFS_STATUS: avsReadData <= {27'h0000000, overrun_reg, vgaGainB, vgaGainA};
				default: avsReadData <= 32'h00000000;
			endcase
		end
	end

	// ==========================================
	// Oscillator and decimation timing
	reg [31:0] phase_reg;
	reg [15:0] decCnt_reg;
	// At or past the end, so a ratio lowered mid-span never waits for a wrap
	wire dump = enable && (decCnt_reg >= decim_reg - 16'h0001);

	// Phase accumulator and decimation counter
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase_reg <= 32'h00000000;
			decCnt_reg <= 16'h0000;
		end
		else if (!enable)
		begin
			phase_reg <= 32'h00000000;
			decCnt_reg <= 16'h0000;
		end
		else
		begin
			phase_reg <= phase_reg + nco_reg;
			decCnt_reg <= dump ? 16'h0000 : decCnt_reg + 16'h0001;
		end
	end

	// ==========================================
	// Per channel path: sync, gain, mix, integrate and dump
	wire [2*ADC_W-1:0] adcBus = {adcDataB, adcDataA};
	wire [2*ACC_W-1:0] iBus;
	wire [2*ACC_W-1:0] qBus;
	wire [3:0] gainBus;
	wire [1:0] quad = phase_reg[31:30];
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1)
		begin : path
			reg [ADC_W-1:0] sync1_reg;
			reg [ADC_W-1:0] sync2_reg;
			reg [1:0] gain_reg;
			reg [1:0] gainD1_reg;
			reg [1:0] gainD2_reg;
			reg [ADC_W-1:0] peak_reg;
			reg signed [ACC_W-1:0] accI_reg;
			reg signed [ACC_W-1:0] accQ_reg;
			reg signed [ACC_W-1:0] outI_reg;
			reg signed [ACC_W-1:0] outQ_reg;
			wire signed [ACC_W-1:0] wide;
			wire signed [ACC_W-1:0] comp;
			wire signed [ACC_W-1:0] mixI;
			wire signed [ACC_W-1:0] mixQ;
			wire signed [ACC_W-1:0] sumI;
			wire signed [ACC_W-1:0] sumQ;
			wire [ADC_W-1:0] mag;

			// Gain undone by shifting back up by the commanded steps
			assign wide = {{(ACC_W-ADC_W){sync2_reg[ADC_W-1]}}, sync2_reg};
			assign comp = wide <<< gainD2_reg;
			// Quarter-wave oscillator; sign only, so no multiplier
			assign mixI = (quad == 2'h0) ? comp : (quad == 2'h2) ? -comp : {ACC_W{1'b0}};
			assign mixQ = (quad == 2'h3) ? comp : (quad == 2'h1) ? -comp : {ACC_W{1'b0}};
			assign sumI = accI_reg + mixI;
			assign sumQ = accQ_reg + mixQ;
			assign mag = sync2_reg[ADC_W-1] ? (~sync2_reg + 1'b1) : sync2_reg;
			assign iBus[ch*ACC_W +: ACC_W] = outI_reg;
			assign qBus[ch*ACC_W +: ACC_W] = outQ_reg;
			assign gainBus[ch*2 +: 2] = gain_reg;

			// Two flops on the pin data; the gain delay matches them
			always @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					sync1_reg <= {ADC_W{1'b0}};
					sync2_reg <= {ADC_W{1'b0}};
					gainD1_reg <= 2'h0;
					gainD2_reg <= 2'h0;
				end
				else
				begin
					sync1_reg <= adcBus[ch*ADC_W +: ADC_W];
					sync2_reg <= sync1_reg;
					gainD1_reg <= gain_reg;
					gainD2_reg <= gainD1_reg;
				end
			end

			// Boxcar over the whole decimation span: nulls land on fs and its images
			always @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					accI_reg <= {ACC_W{1'b0}};
					accQ_reg <= {ACC_W{1'b0}};
					outI_reg <= {ACC_W{1'b0}};
					outQ_reg <= {ACC_W{1'b0}};
				end
				else if (!enable)
				begin
					accI_reg <= {ACC_W{1'b0}};
					accQ_reg <= {ACC_W{1'b0}};
				end
				else if (dump)
				begin
					accI_reg <= {ACC_W{1'b0}};
					accQ_reg <= {ACC_W{1'b0}};
					outI_reg <= sumI >>> shift_reg;
					outQ_reg <= sumQ >>> shift_reg;
				end
				else
				begin
					accI_reg <= sumI;
					accQ_reg <= sumQ;
				end
			end

			// Peak per output sample; 12 dB hysteresis avoids hunting
			always @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					peak_reg <= {ADC_W{1'b0}};
					gain_reg <= 2'h0;
				end
				else if (dump)
				begin
					peak_reg <= {ADC_W{1'b0}};
					if (!agcEnable)
						gain_reg <= gain_reg;
					else if (peak_reg >= agcThr_reg && gain_reg != `TSOF_GAIN_MAX)
						gain_reg <= gain_reg + 2'h1;
					else if (peak_reg < (agcThr_reg >> 2) && gain_reg != 2'h0)
						gain_reg <= gain_reg - 2'h1;
				end
				else if (mag > peak_reg)
					peak_reg <= mag;
			end
		end
	endgenerate

	assign vgaGainA = gainBus[1:0];
	assign vgaGainB = gainBus[3:2];

	// ==========================================
	// Frame loader into the FIFO
	reg [ACC_W-1:0] frame_reg [0:3];
	reg [1:0] pushIdx_reg;
	reg pending_reg;
	wire fifoInReady;
	wire [ACC_W+1:0] fifoOutData;
	wire fifoOutValid;
	wire fifoPop;
	wire lastPush = channelMuxSelect ? (pushIdx_reg == 2'h3) : (pushIdx_reg == 2'h1);
	wire pushFire = pending_reg && fifoInReady;

	// Loader stalls on a full FIFO; a dump while still busy is an overrun
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pending_reg <= 1'b0;
			pushIdx_reg <= 2'h0;
			overrun_reg <= 1'b0;
			frame_reg[0] <= {ACC_W{1'b0}};
			frame_reg[1] <= {ACC_W{1'b0}};
			frame_reg[2] <= {ACC_W{1'b0}};
			frame_reg[3] <= {ACC_W{1'b0}};
		end
		else
		begin
			if (dump && pending_reg && !(pushFire && lastPush))
				overrun_reg <= 1'b1;
			else if (busDone && avsWrite && avsAddress == `TSOF_OFS_STATUS
				&& avsWriteData[`TSOF_ST_OVERRUN])
				overrun_reg <= 1'b0;
			if (pushFire)
				pushIdx_reg <= lastPush ? 2'h0 : pushIdx_reg + 2'h1;
			if (dump && (!pending_reg || (pushFire && lastPush)))
			begin
				// Order AI, AQ, BI, BQ
				frame_reg[0] <= iBus[ACC_W-1:0];
				frame_reg[1] <= qBus[ACC_W-1:0];
				frame_reg[2] <= iBus[2*ACC_W-1:ACC_W];
				frame_reg[3] <= qBus[2*ACC_W-1:ACC_W];
				pending_reg <= 1'b1;
			end
			else if (pushFire && lastPush)
				pending_reg <= 1'b0;
		end
	end

	// Tag bits travel with each word: {isChannelB, isQuadrature}
	tsof_fifo #(
		.WIDTH(ACC_W + 2),
		.DEPTH(FIFO_DEPTH),
		.AW(2)
	) wordFifo (
		.clk(clk),
		.arst_n(arst_n),
		.inData({pushIdx_reg, frame_reg[pushIdx_reg]}),
		.inValid(pending_reg),
		.inReady(fifoInReady),
		.outData(fifoOutData),
		.outValid(fifoOutValid),
		.outReady(fifoPop)
	);

	// ==========================================
	// Serializer: bit clock is clk/2, data changes as it rises
	reg [ACC_W-1:0] shiftOut_reg;
	reg [4:0] bitCnt_reg;
	wire wordStart = !serialBitClock && (bitCnt_reg == 5'h00);
	assign fifoPop = wordStart && fifoOutValid;

	// Shift MSB first; sync marks the I word of each pair
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			serialBitClock <= 1'b0;
			serialFrameSync <= 1'b0;
			channelASerialOut <= 1'b0;
			outputReady <= 1'b0;
			shiftOut_reg <= {ACC_W{1'b0}};
			bitCnt_reg <= 5'h00;
		end
		else
		begin
			serialBitClock <= ~serialBitClock;
			if (wordStart)
			begin
				if (fifoOutValid)
				begin
					channelASerialOut <= fifoOutData[ACC_W-1];
					shiftOut_reg <= {fifoOutData[ACC_W-2:0], 1'b0};
					bitCnt_reg <= `TSOF_BITCNT_LAST;
					serialFrameSync <= ~fifoOutData[ACC_W];
					outputReady <= ~fifoOutData[ACC_W+1];
				end
				else
				begin
					channelASerialOut <= 1'b0;
					serialFrameSync <= 1'b0;
				end
			end
			else if (!serialBitClock)
			begin
				channelASerialOut <= shiftOut_reg[ACC_W-1];
				shiftOut_reg <= {shiftOut_reg[ACC_W-2:0], 1'b0};
				bitCnt_reg <= bitCnt_reg - 5'h01;
				serialFrameSync <= 1'b0;
			end
		end
	end
endmodule // tsof_formatter

// [bench/tsof_formatter_asserts.sv]
`timescale 1ns/10ps
// ========
// Bus and serial link timing checks
module tsof_formatter_asserts (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Bus handshake
	input wire avsRead,
	input wire avsWrite,
	input wire avsWaitrequest,
	// Serial link
	input wire serialBitClock,
	input wire serialFrameSync,
	input wire channelASerialOut,
	input wire outputReady
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// Sync spans one bit period, two core clocks
	sequence sSyncBit;
		serialFrameSync [*2] ##1 !serialFrameSync;
	endsequence
	// Channel A in-phase word start
	sequence sWordAI;
		$rose(serialFrameSync) && outputReady;
	endsequence
	a_bit_clock_half: assert property ($past(arst_n) |-> serialBitClock != $past(serialBitClock))
		else $error("bit clock missed a toggle");
	a_wait_one_cycle: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
		else $error("waitrequest not low after one wait cycle");
	a_wait_release: assert property (!avsWaitrequest |=> avsWaitrequest)
		else $error("waitrequest low longer than one cycle");
	a_sync_one_bit: assert property ($rose(serialFrameSync) |-> sSyncBit)
		else $error("frame sync width wrong");
	a_sync_on_rise: assert property ($rose(serialFrameSync) |-> $rose(serialBitClock))
		else $error("frame sync off the bit clock rise");
	a_data_on_rise: assert property ($changed(channelASerialOut) |-> $rose(serialBitClock))
		else $error("serial data changed off the bit clock rise");
	a_ready_word_edge: assert property ($changed(outputReady) |-> $rose(serialBitClock))
		else $error("ready changed inside a bit");
	a_ready_starts_a: assert property ($rose(outputReady) |-> $rose(serialFrameSync))
		else $error("ready rose without a sync");
	a_b_follows_a: assert property ($rose(serialFrameSync) && !outputReady |-> $past(outputReady))
		else $error("channel B word not right after channel A");
	a_word_length: assert property (sWordAI |-> ##48 outputReady && $rose(serialBitClock))
		else $error("quadrature word not 48 clocks after in-phase");
	a_word_spacing: assert property (sWordAI |->
		##96 ($rose(serialFrameSync) || outputReady))
		else $error("channel B word not two words after channel A");
endmodule // tsof_formatter_asserts

// [bench/tsof_serial_capture.sv]
`timescale 1ns/10ps
// ========
// Serial port receiver in continuous mode
module tsof_serial_capture (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Serial link
	input wire serialBitClock,
	input wire serialFrameSync,
	input wire channelASerialOut,
	input wire outputReady,
	// Received words
	output wire gatedSync,
	output reg [23:0] word,
	output reg wordSync,
	output reg wordReady,
	output reg wordValid
);
	reg bitClockPrev;
	reg run;
	reg s;
	reg r;
	reg [23:0] sh;
	integer n;
	// Outside gate keeps only the channel A sync
	assign gatedSync = serialFrameSync & outputReady;
	// Sample on bit clock fall; a sync restarts the word count
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bitClockPrev <= 1'b0;
			wordValid <= 1'b0;
			run = 1'b0;
			n = 0;
		end
		else
		begin
			bitClockPrev <= serialBitClock;
			wordValid <= 1'b0;
			if (bitClockPrev && !serialBitClock && (run || serialFrameSync))
			begin
				if (serialFrameSync || n == 0)
				begin
					n = 0;
					s = serialFrameSync;
					r = outputReady;
				end
				sh = {sh[22:0], channelASerialOut};
				n = n + 1;
				run = 1'b1;
				if (n == 24)
				begin
					word <= sh;
					wordSync <= s;
					wordReady <= r;
					wordValid <= 1'b1;
					n = 0;
				end
			end
		end
	end
endmodule // tsof_serial_capture

// [bench/tb_top.sv]
`timescale 1ns/10ps
`include "tsof_regs.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end
// ========
// Self-checking bench
module tb_top;
	reg clk = 1'b0;
	reg arst_n = 1'b0;
	reg [4:0] avsAddress = 5'h00;
	reg avsRead = 1'b0;
	reg avsWrite = 1'b0;
	reg [31:0] avsWriteData = 32'h0;
	reg [11:0] adcDataA = 12'h000;
	reg [11:0] adcDataB = 12'h7ff;
	wire [31:0] avsReadData;
	wire avsWaitrequest, sBck, serial_frame_sync, sOut, sRdy, gSync, wordSync, wordReady, wordValid;
	wire [1:0] gainA, gainB;
	wire [23:0] word;
	reg [31:0] q;
	reg [23:0] w;
	reg ws, wr;
	int n_fail = 0, checked = 0, cyc = 0, tw, t0, nGate = 0, g0;
	reg gPrev = 1'b0;
	// Core clock, 50 ns
	always #25 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	// Rises of the gated sync; only channel A may pass the gate
	always @(posedge clk)
	begin
		gPrev <= gSync;
		if (gSync && !gPrev)
			nGate <= nGate + 1;
	end
	tsof_formatter u_tsof_formatter (.clk(clk), .arst_n(arst_n), .avsAddress(avsAddress),
		.avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
		.avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest), .adcDataA(adcDataA),
		.adcDataB(adcDataB), .vgaGainA(gainA), .vgaGainB(gainB), .serialBitClock(sBck),
		.serialFrameSync(serial_frame_sync), .channelASerialOut(sOut), .outputReady(sRdy));
	tsof_serial_capture u_tsof_serial_capture (.clk(clk), .arst_n(arst_n),
		.serialBitClock(sBck), .serialFrameSync(serial_frame_sync), .channelASerialOut(sOut),
		.outputReady(sRdy), .gatedSync(gSync), .word(word), .wordSync(wordSync),
		.wordReady(wordReady), .wordValid(wordValid));
	// ========
	// Avalon master: hold until waitrequest is sampled low
	task bus(input wr_en, input [4:0] a, input [31:0] d);
		int b;
		begin
			b = 0;
			@(posedge clk);
			avsAddress <= a;
			avsWrite <= wr_en;
			avsRead <= !wr_en;
			avsWriteData <= d;
			@(posedge clk);
			while (avsWaitrequest !== 1'b0 && b < 50)
			begin
				@(posedge clk);
				b = b + 1;
			end
			q = avsReadData;
			if (b >= 50) n_fail++;
			avsRead <= 1'b0;
			avsWrite <= 1'b0;
		end
	endtask
	task readChk(input [4:0] a, input [31:0] e);
		begin
			bus(1'b0, a, 32'h0);
			`CHK("readData", e, q)
		end
	endtask
	// Next word from the receiver, bounded wait
	task getWord;
		int b;
		begin
			b = 0;
			@(posedge clk);
			while (wordValid !== 1'b1 && b < 400)
			begin
				@(posedge clk);
				b = b + 1;
			end
			if (b >= 400) n_fail++;
			w = word;
			ws = wordSync;
			wr = wordReady;
			tw = cyc;
		end
	endtask
	// One output sample; channel A input is zero so its words must be zero
	task frame(input mux);
		int b;
		begin
			b = 0;
			getWord;
			while (!(ws === 1'b1 && wr === 1'b1) && b < 12)
			begin
				getWord;
				b = b + 1;
			end
			if (b >= 12) n_fail++;
			t0 = tw;
			g0 = nGate;
			`CHK("wordAI", 24'h0, w)
			getWord;
			`CHK("readyAQ", 1'b1, wr)
			`CHK("syncAQ", 1'b0, ws)
			`CHK("timeAQ", 48, tw - t0)
			`CHK("wordAQ", 24'h0, w)
			if (mux)
			begin
				getWord;
				`CHK("readyBI", 1'b0, wr)
				`CHK("syncBI", 1'b1, ws)
				getWord;
				`CHK("readyBQ", 1'b0, wr)
				`CHK("syncBQ", 1'b0, ws)
			end
			b = 0;
			getWord;
			while (ws !== 1'b1 && b < 12)
			begin
				getWord;
				b = b + 1;
			end
			if (b >= 12) n_fail++;
			`CHK("readyNext", 1'b1, wr)
			`CHK("gateCount", 1, nGate - g0)
			`CHK("timeNext", 192, tw - t0)
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", checked, n_fail);
			if (n_fail == 0 && checked > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// ========
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		readChk(`TSOF_OFS_CTRL, `TSOF_RST_CTRL);
		readChk(`TSOF_OFS_NCO, `TSOF_RST_NCO);
		readChk(`TSOF_OFS_DECIM, `TSOF_RST_DECIM);
		readChk(`TSOF_OFS_AGCTHR, `TSOF_RST_AGCTHR);
		readChk(`TSOF_OFS_SHIFT, `TSOF_RST_SHIFT);
		bus(1'b1, 5'h18, 32'h5a5a5a5a);
		readChk(5'h18, 32'h0);
		frame(1'b1);
		frame(1'b1);
		`CHK("gainA", 2'h0, gainA)
		`CHK("gainB", 2'h3, gainB)
		readChk(`TSOF_OFS_STATUS, 32'h0c);
		// Mux off; let the old frame drain first
		bus(1'b1, `TSOF_OFS_CTRL, 32'h5);
		repeat (400) @(posedge clk);
		frame(1'b0);
		// Too fast a sample rate for the link must flag overrun
		bus(1'b1, `TSOF_OFS_CTRL, 32'h7);
		bus(1'b1, `TSOF_OFS_DECIM, 32'h60);
		readChk(`TSOF_OFS_DECIM, 32'h60);
		repeat (2000) @(posedge clk);
		readChk(`TSOF_OFS_STATUS, 32'h1c);
		bus(1'b1, `TSOF_OFS_CTRL, 32'h5);
		bus(1'b1, `TSOF_OFS_DECIM, 32'hc0);
		repeat (400) @(posedge clk);
		bus(1'b1, `TSOF_OFS_STATUS, 32'h10);
		readChk(`TSOF_OFS_STATUS, 32'h0c);
		tally_and_finish;
	end
	// Watchdog, well past the expected run
	initial
	begin
		#1000000;
		n_fail++;
		tally_and_finish;
	end
endmodule // tb_top
bind tsof_formatter tsof_formatter_asserts u_tsof_formatter_asserts (.clk(clk),
	.arst_n(arst_n), .avsRead(avsRead), .avsWrite(avsWrite),
	.avsWaitrequest(avsWaitrequest), .serialBitClock(serialBitClock),
	.serialFrameSync(serialFrameSync), .channelASerialOut(channelASerialOut),
	.outputReady(outputReady));
